/* common/pstg_pkg.sv */
// Purpose: shared constants for the PWM input stage with cross-conduction guard
// Assumes: primary_oscillator clock at 40 MHz
// Notes: dead time is dead_time_select plus one steps of DEAD_TIME_STEP_NS
package pstg_pkg;
  localparam int CLK_MHZ = 40;
  // Glitch reject time in ns and its cycle count (least time, rounded up)
  localparam int GLITCH_REJECT_TIME_NS = 100;
  localparam int GLITCH_CYCLES = (GLITCH_REJECT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int GLITCH_CNT_W = 4;
  // Dead time select width and step per code in ns
  localparam int DT_SEL_W = 3;
  localparam int DEAD_TIME_STEP_NS = 200;
  localparam int DEAD_TIME_STEP_CYCLES = (DEAD_TIME_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int DT_CNT_W = 8;
  localparam logic [DT_SEL_W-1:0] DT_SEL_RESET = 3'h0;
endpackage : pstg_pkg

/* common/pstg_sync_if.sv */
// Purpose: carries synchronised primary inputs between filter and main stage
// Assumes: single clock domain
// Notes: one producer, one consumer
`timescale 1ns/1ps
`default_nettype none
interface pstg_sync_if;
  logic pwm;
  logic monitor;
  logic enable;
  modport prod (output pwm, output monitor, output enable);
  modport cons (input pwm, input monitor, input enable);
endinterface : pstg_sync_if
`default_nettype wire

/* hw/pstg_in_sync.sv */
// Purpose: two-flop synchronisers plus glitch filter on the PWM input
// Assumes: pins asynchronous to clk
// Notes: filter adds GLITCH_CYCLES of latency to PWM edges
`timescale 1ns/1ps
`default_nettype none
module pstg_in_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwm_in_positive,
  input wire logic shoot_through_monitor_in,
  input wire logic enable_in,
  pstg_sync_if.prod so
);
  import pstg_pkg::*;
  logic [2:0] s1_ff, s2_ff, nxt_s1, nxt_s2;
  logic pwm_f_ff, nxt_pwm_f;
  logic [GLITCH_CNT_W-1:0] gcnt_ff, nxt_gcnt;
  // Synchroniser stages and PWM glitch filter next values
  always_comb begin
    nxt_s1 = {enable_in, shoot_through_monitor_in, pwm_in_positive};
    nxt_s2 = s1_ff;
    nxt_pwm_f = pwm_f_ff;
    nxt_gcnt = '0;
    // A level must hold GLITCH_CYCLES before it is believed
    if (s2_ff[0] != pwm_f_ff) begin
      if (gcnt_ff == GLITCH_CNT_W'(GLITCH_CYCLES - 1)) begin
        nxt_pwm_f = s2_ff[0];
      end else begin
        nxt_gcnt = gcnt_ff + 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
      pwm_f_ff <= 1'b0;
      gcnt_ff <= '0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      pwm_f_ff <= nxt_pwm_f;
      gcnt_ff <= nxt_gcnt;
    end
  end
  assign so.pwm = pwm_f_ff;
  assign so.monitor = s2_ff[1];
  assign so.enable = s2_ff[2];
endmodule : pstg_in_sync
`default_nettype wire

/* hw/pstg_top.sv */
// Purpose: PWM input stage with cross-conduction protection
// Assumes: enable_in is already a qualified validity level
// Notes: outputs are registered except inhibition_active_flag, an OR of registers; pwm_cmd also gates the output oscillator
`timescale 1ns/1ps
`default_nettype none
module pstg_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pwm_in_positive,
  input wire logic shoot_through_monitor_in,
  input wire logic enable_in,
  input wire logic [pstg_pkg::DT_SEL_W-1:0] dead_time_select,
  input wire logic error_clear,
  output logic pwm_cmd,
  output logic output_start_stop_oscillator,
  output logic inhibition_active_flag,
  output logic suppressed_edge_error_flag
);
  import pstg_pkg::*;
  logic rs1_ff, rst_n;
  pstg_sync_if sif ();
  // Reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rs1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rst_n <= rs1_ff;
    end
  end
  pstg_in_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pwm_in_positive(pwm_in_positive),
    .shoot_through_monitor_in(shoot_through_monitor_in),
    .enable_in(enable_in),
    .so(sif.prod)
  );
  typedef enum logic [1:0] {
    PSTG_IDLE = 2'b01,
    PSTG_DEAD = 2'b10
  } pstg_inh_e;
  pstg_inh_e st_ff, nxt_st;
  logic [DT_CNT_W-1:0] dcnt_ff, nxt_dcnt;
  logic pwm_prev_ff, nxt_pwm_prev;
  logic cmd_ff, nxt_cmd;
  logic err_ff, nxt_err;
  logic inhibit;
  logic rise;
  logic [DT_CNT_W-1:0] dead_cycles;
  // Dead time per code; code 0 still appends one step
  assign dead_cycles = DT_CNT_W'((32'(dead_time_select) + 1) * DEAD_TIME_STEP_CYCLES);
  // Inhibit covers the synchronised monitor pulse and the dead time tail
  assign inhibit = sif.monitor || (st_ff == PSTG_DEAD);
  assign rise = sif.pwm && !pwm_prev_ff;
  // Inhibit sequencer, command and error next values
  always_comb begin
    nxt_st = st_ff;
    nxt_dcnt = dcnt_ff;
    nxt_pwm_prev = sif.pwm;
    nxt_cmd = cmd_ff;
    nxt_err = err_ff;
    case (st_ff)
      PSTG_IDLE: begin
        nxt_dcnt = '0;
      end
      PSTG_DEAD: begin
        if (dcnt_ff <= 8'h01) begin
          nxt_st = PSTG_IDLE;
          nxt_dcnt = '0;
        end else begin
          nxt_dcnt = dcnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_st = PSTG_IDLE;
        nxt_dcnt = '0;
      end
    endcase
    // Monitor high restarts the tail so it is counted from the pulse end
    if (sif.monitor) begin
      nxt_st = PSTG_DEAD;
      nxt_dcnt = dead_cycles;
    end
    // Command: on only from an allowed rising edge, off on PWM low
    if (!sif.enable) begin
      nxt_cmd = 1'b0;
    end else if (!sif.pwm) begin
      nxt_cmd = 1'b0;
    end else if (rise && !inhibit) begin
      nxt_cmd = 1'b1;
    end
    // An on command survives inhibit; only PWM low or enable drops it
    // Only inhibits seen on a clock edge can suppress, so sub-cycle ones between edges don't
    if (error_clear) begin
      nxt_err = 1'b0;
    end
    if (rise && inhibit && sif.enable) begin
      nxt_err = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= PSTG_IDLE;
      dcnt_ff <= '0;
      pwm_prev_ff <= 1'b0;
      cmd_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      dcnt_ff <= nxt_dcnt;
      pwm_prev_ff <= nxt_pwm_prev;
      cmd_ff <= nxt_cmd;
      err_ff <= nxt_err;
    end
  end
  assign pwm_cmd = cmd_ff;
  assign output_start_stop_oscillator = cmd_ff;
  assign inhibition_active_flag = inhibit;
  assign suppressed_edge_error_flag = err_ff;

  // Steps of the protection: a pulse, its falling end and a blocked edge
  sequence s_mon_high;
    sif.monitor;
  endsequence
  sequence s_mon_fall;
    sif.monitor ##1 !sif.monitor;
  endsequence
  sequence s_blocked_rise;
    rise && inhibit && sif.enable;
  endsequence

  // Command follows enable and the PWM level
  a_off_when_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    !sif.enable |=> !pwm_cmd)
    else $error("command on while disabled");
  a_off_on_low: assert property (@(posedge clk) disable iff (!rst_n)
    !sif.pwm |=> !pwm_cmd)
    else $error("command on while pwm low");
  a_on_rise: assert property (@(posedge clk) disable iff (!rst_n)
    rise && !inhibit && sif.enable |=> pwm_cmd)
    else $error("turn-on missed");

  // Blocked edges never turn on; a turn-on always has an allowed cause
  a_no_rise_inh: assert property (@(posedge clk) disable iff (!rst_n)
    rise && inhibit |=> !pwm_cmd)
    else $error("turn-on during inhibit");
  a_rose_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pwm_cmd) |-> $past(rise && !inhibit && sif.enable))
    else $error("turn-on without allowed edge");
  a_hold_on: assert property (@(posedge clk) disable iff (!rst_n)
    pwm_cmd && sif.pwm && sif.enable && inhibit |=> pwm_cmd)
    else $error("inhibit forced off");

  // Error flag: set on a blocked edge, sticky, and set beats clear
  a_err_set: assert property (@(posedge clk) disable iff (!rst_n)
    s_blocked_rise |=> suppressed_edge_error_flag)
    else $error("error not set");
  a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    s_blocked_rise ##0 error_clear |=> suppressed_edge_error_flag)
    else $error("clear beat a blocked edge");
  a_err_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    suppressed_edge_error_flag && !error_clear |=> suppressed_edge_error_flag)
    else $error("error flag dropped by itself");
  a_err_clear: assert property (@(posedge clk) disable iff (!rst_n)
    error_clear && !(rise && inhibit && sif.enable) |=> !suppressed_edge_error_flag)
    else $error("error flag not cleared");
  // Disabled stage is off anyway, so it raises no error
  a_no_err_off: assert property (@(posedge clk) disable iff (!rst_n)
    !sif.enable && !suppressed_edge_error_flag |=> !suppressed_edge_error_flag)
    else $error("error raised while disabled");

  // Inhibit sequencer: one-hot state, counter load and idle count
  a_state_onehot: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot(st_ff))
    else $error("inhibit state not one-hot");
  a_dead_load: assert property (@(posedge clk) disable iff (!rst_n)
    s_mon_high |=> (st_ff == PSTG_DEAD) && (dcnt_ff == $past(dead_cycles)))
    else $error("dead time not loaded");
  a_idle_count: assert property (@(posedge clk) disable iff (!rst_n)
    st_ff == PSTG_IDLE |-> dcnt_ff == '0)
    else $error("counter running while idle");

  // Flag covers the pulse and the tail, and nothing else
  a_dead_tail: assert property (@(posedge clk) disable iff (!rst_n)
    s_mon_fall |-> inhibition_active_flag)
    else $error("no dead time tail");
  // Shortest tail is one step of eight cycles, whatever the code
  a_tail_min: assert property (@(posedge clk) disable iff (!rst_n)
    s_mon_fall |-> inhibition_active_flag [*8])
    else $error("dead time tail too short");
  a_flag_match: assert property (@(posedge clk) disable iff (!rst_n)
    sif.monitor |-> inhibition_active_flag)
    else $error("flag off during pulse");
  a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == PSTG_IDLE) && !sif.monitor |-> !inhibition_active_flag)
    else $error("flag on outside inhibit");
  a_tail_ends: assert property (@(posedge clk) disable iff (!rst_n)
    (st_ff == PSTG_DEAD) && !sif.monitor && dcnt_ff == 8'h01 |=> !inhibition_active_flag || sif.monitor)
    else $error("tail overruns");

  // Output oscillator is gated by the command itself
  a_osc_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    output_start_stop_oscillator == pwm_cmd)
    else $error("oscillator not following");
endmodule : pstg_top
`default_nettype wire

/* dv/pstg_mcu_model.sv */
// Purpose: controller PWM timer outputs facing the input stage
// Assumes: pins change just after a rising clock edge
// Notes: pins are always driven, so pull-downs never matter
`timescale 1ns/1ps
`default_nettype none
module pstg_mcu_model (
  input wire logic clk,
  output logic pwm,
  output logic mon,
  output logic en
);
  initial begin
    pwm = 1'b0;
    mon = 1'b0;
    en = 1'b0;
  end
  // Levels move on the edge, so sampling order cannot matter
  task automatic drive(input logic p, input logic m, input logic e);
    @(posedge clk);
    pwm <= p;
    mon <= m;
    en <= e;
  endtask : drive
  // Enable first, then a settle wait before PWM may rise
  task automatic enable_up();
    drive(1'b0, 1'b0, 1'b1);
    repeat (8) @(posedge clk);
  endtask : enable_up
endmodule : pstg_mcu_model
`default_nettype wire

/* dv/pstg_top_tb.sv */
// Purpose: self-checking bench for the PWM input stage
// Assumes: 40 MHz clock, dead time step from the package
// Notes: waits on the command are bounded, sub-cycle inhibits not tested
`timescale 1ns/1ps
`default_nettype none
module pstg_top_tb;
  import pstg_pkg::*;
  logic clk, nrst, pwm, mon, en, err_clr, cmd, osc, flag, err;
  logic [DT_SEL_W-1:0] sel;
  int mismatches, checks;
  pstg_mcu_model mcu (.clk(clk), .pwm(pwm), .mon(mon), .en(en));
  pstg_top dut (.clk(clk), .nrst(nrst), .pwm_in_positive(pwm),
    .shoot_through_monitor_in(mon), .enable_in(en), .dead_time_select(sel),
    .error_clear(err_clr), .pwm_cmd(cmd), .output_start_stop_oscillator(osc),
    .inhibition_active_flag(flag), .suppressed_edge_error_flag(err));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string name, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  // Bounded wait; a hang ends the run
  task automatic wait_cmd(input logic v);
    for (int n = 0; n < 20 && cmd !== v; n++) @(negedge clk);
    check("cmd", cmd, v);
    if (cmd !== v) stop_test();
  endtask : wait_cmd
  task automatic t_on_off();
    mcu.enable_up();
    mcu.drive(1'b1, 1'b0, 1'b1);
    wait_cmd(1'b1);
    check("osc", osc, 1'b1);
    mcu.drive(1'b0, 1'b0, 1'b1);
    wait_cmd(1'b0);
    check("osc", osc, 1'b0);
  endtask : t_on_off
  task automatic t_enable_off();
    mcu.drive(1'b1, 1'b0, 1'b0);
    repeat (14) @(negedge clk);
    check("cmd", cmd, 1'b0);
    check("err", err, 1'b0);
    mcu.drive(1'b0, 1'b0, 1'b0);
  endtask : t_enable_off
  // Two-cycle pulse is below the reject time
  task automatic t_glitch();
    mcu.enable_up();
    mcu.drive(1'b1, 1'b0, 1'b1);
    mcu.drive(1'b1, 1'b0, 1'b1);
    mcu.drive(1'b0, 1'b0, 1'b1);
    repeat (14) @(negedge clk);
    check("cmd", cmd, 1'b0);
  endtask : t_glitch
  // Flag length is a 4-cycle pulse plus the selected dead time
  task automatic t_dead();
    int n;
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      sel <= s[DT_SEL_W-1:0];
      n = 0;
      mcu.drive(1'b0, 1'b1, 1'b1);
      for (int i = 0; i < 120; i++) begin
        if (i == 3) mcu.drive(1'b0, 1'b0, 1'b1);
        else @(posedge clk);
        @(negedge clk);
        if (flag === 1'b1) n++;
      end
      check("flag_len", n == 4 + (s + 1) * DEAD_TIME_STEP_CYCLES, 1'b1);
    end
  endtask : t_dead
  task automatic t_suppress();
    @(posedge clk);
    sel <= 3'h0;
    mcu.drive(1'b0, 1'b1, 1'b1);
    repeat (4) @(negedge clk);
    mcu.drive(1'b1, 1'b1, 1'b1);
    repeat (14) @(negedge clk);
    check("cmd", cmd, 1'b0);
    check("err", err, 1'b1);
    mcu.drive(1'b0, 1'b0, 1'b1);
    repeat (30) @(posedge clk);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    @(negedge clk);
    check("err_clr", err, 1'b0);
  endtask : t_suppress
  // An on command survives a monitor pulse
  task automatic t_hold_on();
    mcu.drive(1'b1, 1'b0, 1'b1);
    wait_cmd(1'b1);
    mcu.drive(1'b1, 1'b1, 1'b1);
    repeat (6) @(negedge clk);
    check("flag", flag, 1'b1);
    check("cmd", cmd, 1'b1);
    mcu.drive(1'b0, 1'b0, 1'b1);
    wait_cmd(1'b0);
    check("err", err, 1'b0);
  endtask : t_hold_on
  // Reset, then every scenario in turn
  initial begin
    nrst = 1'b0;
    err_clr = 1'b0;
    sel = 3'h0;
    mismatches = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_on_off();
    t_enable_off();
    t_glitch();
    t_dead();
    t_suppress();
    t_hold_on();
    stop_test();
  end
endmodule : pstg_top_tb
`default_nettype wire
